/* inc/ascc_pkg.sv */
// Purpose: Shared constants and types for the converter status, clock and channel register block
// Assumes: Avalon-MM word registers, byte address = 4 * register index
// Notes:   Stage codes are used by the design and by the bench, field positions by the design only
package ascc_pkg;

   // ----------------------------------------
   // Register indices (byte address is four times these)
   // ----------------------------------------
   localparam logic [12:0] IDX_INPUT_SEL = 13'h1d1f;
   localparam logic [12:0] IDX_PRECHARGE = 13'h1d24;
   localparam logic [12:0] IDX_STATUS    = 13'h1d2a;
   localparam logic [12:0] IDX_REF_SEL   = 13'h1d2b;
   localparam logic [12:0] IDX_CLK_DIV   = 13'h1d2d;
   localparam logic [12:0] IDX_CONTROL   = 13'h1d30;
   localparam logic [12:0] IDX_IRQ_STS   = 13'h1d31;
   localparam logic [12:0] IDX_IRQ_MASK  = 13'h1d32;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int STS_AOV_BIT  = 7;
   localparam int STS_UTH_BIT  = 6;
   localparam int STS_LTH_BIT  = 5;
   localparam int STS_COMPUTATION_UPDATED_FLAG_BIT = 4;
   localparam int CTL_DSE_BIT  = 0;
   localparam int CTL_RPT_BIT  = 1;
   localparam int CTL_SRC_BIT  = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_OVF_BIT  = 1;
   localparam int IRQ_THR_BIT  = 2;

   // ----------------------------------------
   // Reset values and codes
   // ----------------------------------------
   localparam logic [5:0]  RST_INPUT_SEL = 6'h00;
   localparam logic [12:0] RST_PRECHARGE = 13'h0000;
   localparam logic [1:0]  RST_REF_SEL   = 2'h0;
   localparam logic [5:0]  RST_CLK_DIV   = 6'h00;
   localparam logic [2:0]  RST_CONTROL   = 3'h0;
   localparam logic [2:0]  RST_IRQ       = 3'h0;
   localparam logic [6:0]  CLK_DIV_FACTOR = 7'h02;
   localparam logic [2:0]  STG_IDLE = 3'h0;
   localparam logic [2:0]  STG_PRE1 = 3'h1;
   localparam logic [2:0]  STG_ACQ1 = 3'h2;
   localparam logic [2:0]  STG_CNV1 = 3'h3;
   localparam logic [2:0]  STG_SUSP = 3'h4;
   localparam logic [2:0]  STG_PRE2 = 3'h5;
   localparam logic [2:0]  STG_ACQ2 = 3'h6;
   localparam logic [2:0]  STG_CNV2 = 3'h7;
   localparam logic [1:0]  REF_SUPPLY = 2'h0;
   localparam logic [1:0]  REF_PIN    = 2'h2;
   localparam logic [1:0]  REF_FIXED  = 2'h3;

   typedef enum logic [2:0] {S_IDLE, S_PRE1, S_ACQ1, S_CNV1, S_SUSP, S_PRE2, S_ACQ2, S_CNV2} ascc_seq_t;

   // Flags from the computation datapath, same clock
   typedef struct packed {
      logic overflow;     // Accumulator, filter or error overflow event
      logic above_upper;  // Error value above upper threshold (level)
      logic below_lower;  // Error value below lower threshold (level)
      logic updated;      // Computation results changing (pulse)
      logic acc_clear;    // Accumulator clear completed (pulse)
   } ascc_dp_t;

endpackage

/* verilog/ascc_regs.sv */
// Purpose: Status, clock divider, reference, channel and precharge registers with the stage sequencer
// Assumes: One 250 MHz clock CLK, async active-low RST_N, Avalon-MM slave with waitrequest
// Notes:   Register slice with its own stage sequencer and converter clock enable
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
module ascc_regs
   import ascc_pkg::*;
#(
   parameter logic [12:0] ACQ_CLKS  = 13'h0010,
   parameter logic [12:0] CONV_CLKS = 13'h000c
) (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic [14:0] ADDRESS,
   input  wire logic        READ,
   input  wire logic        WRITE,
   input  wire logic [31:0] WRITEDATA,
   input  wire logic [3:0]  BYTEENABLE,
   output logic      [31:0] READDATA,
   output logic             WAITREQUEST,
   input  wire logic        RC_CLK,
   input  wire logic        TRIGGER,
   input  wire ascc_dp_t    DP_FLAGS,
   output logic             CONV_CLK_EN,
   output logic      [2:0]  STAGE,
   output logic             COMPUTE_GO,
   output logic      [1:0]  REF_SEL,
   output logic      [5:0]  INPUT_SEL,
   output logic             IRQ
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      ascc_seq_t   seq;
      logic [12:0] cnt;
      logic [6:0]  div_cnt;
      logic [2:0]  rc_sync;
      logic        rc_lvl;
      logic        ce;
      logic [5:0]  chan;
      logic [12:0] pre;
      logic [1:0]  refsel;
      logic [5:0]  div;
      logic [2:0]  ctrl;
      logic        accum_overflow_flag;
      logic        uth;
      logic        lth;
      logic        computation_updated_flag;
      logic [2:0]  stage;
      logic        go;
      logic [2:0]  irq_sts;
      logic [2:0]  irq_msk;
      logic        irq;
      logic        waitreq;
      logic [31:0] rdata;
   } ascc_state_t;

   ascc_state_t s_q;
   ascc_state_t s_d;

   logic [12:0] idx;
   logic [6:0]  div_lim;
   logic        wr_now;
   logic        suspended;
   logic [31:0] rd_mux;

   assign idx       = ADDRESS[14:2];
   assign wr_now    = WRITE && !s_q.waitreq;
   assign suspended = (s_q.stage == STG_SUSP);
   // Divide by 2(n+1): the counter wraps at 2(n+1)-1
   assign div_lim   = 7'((CLK_DIV_FACTOR * ({1'b0, s_q.div} + 7'h01)) - 7'h01);

   // ----------------------------------------
   // Read multiplexer
   // ----------------------------------------
   // Unmapped words read as zero; narrow registers sit in low bits
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (idx)
         IDX_INPUT_SEL: rd_mux[5:0]  = s_q.chan;
         IDX_PRECHARGE: rd_mux[12:0] = s_q.pre;
         IDX_STATUS:    rd_mux[7:0]  = {s_q.accum_overflow_flag, s_q.uth, s_q.lth, s_q.computation_updated_flag, 1'b0, s_q.stage};
         IDX_REF_SEL:   rd_mux[1:0]  = s_q.refsel;
         IDX_CLK_DIV:   rd_mux[5:0]  = s_q.div;
         IDX_CONTROL:   rd_mux[2:0]  = s_q.ctrl;
         IDX_IRQ_STS:   rd_mux[2:0]  = s_q.irq_sts;
         IDX_IRQ_MASK:  rd_mux[2:0]  = s_q.irq_msk;
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Software writes are applied first so hardware sets below win a same-cycle clear
   always_comb begin
      s_d = s_q;
      s_d.go = 1'b0;
      // Bus handshake: one wait cycle, then the access completes
      if (s_q.waitreq && (READ || WRITE)) begin
         s_d.waitreq = 1'b0;
         s_d.rdata   = rd_mux;
      end else if (!s_q.waitreq) begin
         s_d.waitreq = 1'b1;
      end
      if (wr_now) begin
         unique case (idx)
            IDX_INPUT_SEL: begin
               if (BYTEENABLE[0]) begin
                  s_d.chan = WRITEDATA[5:0];
               end
            end
            IDX_PRECHARGE: begin
               if (BYTEENABLE[0]) begin
                  s_d.pre[7:0] = WRITEDATA[7:0];
               end
               if (BYTEENABLE[1]) begin
                  s_d.pre[12:8] = WRITEDATA[12:8];
               end
            end
            IDX_STATUS: begin
               if (BYTEENABLE[0]) begin
                  if (WRITEDATA[STS_AOV_BIT]) begin
                     s_d.accum_overflow_flag = 1'b0;
                  end
                  // Clear refused while the computation is suspended
                  if (!suspended) begin
                     s_d.computation_updated_flag = WRITEDATA[STS_COMPUTATION_UPDATED_FLAG_BIT];
                  end
               end
            end
            IDX_REF_SEL: begin
               if (BYTEENABLE[0]) begin
                  s_d.refsel = WRITEDATA[1:0];
               end
            end
            IDX_CLK_DIV: begin
               if (BYTEENABLE[0]) begin
                  s_d.div = WRITEDATA[5:0];
               end
            end
            IDX_CONTROL: begin
               if (BYTEENABLE[0]) begin
                  s_d.ctrl = WRITEDATA[2:0];
               end
            end
            IDX_IRQ_STS: begin
               if (BYTEENABLE[0]) begin
                  s_d.irq_sts = s_q.irq_sts & ~WRITEDATA[2:0];
               end
            end
            IDX_IRQ_MASK: begin
               if (BYTEENABLE[0]) begin
                  s_d.irq_msk = WRITEDATA[2:0];
               end
            end
            default: s_d.rdata = s_d.rdata;
         endcase
      end

      // Datapath flags; the overflow flag is sticky until cleared
      if (DP_FLAGS.acc_clear) begin
         s_d.accum_overflow_flag = 1'b0;
      end
      if (DP_FLAGS.overflow) begin
         s_d.accum_overflow_flag = 1'b1;
      end
      s_d.uth = DP_FLAGS.above_upper;
      s_d.lth = DP_FLAGS.below_lower;
      if (DP_FLAGS.updated) begin
         s_d.computation_updated_flag = 1'b1;
      end

      // Converter clock enable: RC pin edge or divided system clock
      s_d.rc_sync = {s_q.rc_sync[1:0], RC_CLK};
      s_d.ce = 1'b0;
      if (s_q.rc_sync[1] == s_q.rc_sync[2] && s_q.rc_sync[2] != s_q.rc_lvl) begin
         s_d.rc_lvl = s_q.rc_sync[2];
      end
      if (s_q.ctrl[CTL_SRC_BIT]) begin
         // Divider bypassed; a slow system clock may miss RC edges
         s_d.div_cnt = 7'h00;
         s_d.ce = (s_q.rc_sync[1] == s_q.rc_sync[2]) && s_q.rc_sync[2] && !s_q.rc_lvl;
      end else if (s_q.div_cnt >= div_lim) begin
         s_d.div_cnt = 7'h00;
         s_d.ce = 1'b1;
      end else begin
         s_d.div_cnt = s_q.div_cnt + 7'h01;
      end

      // Conversion sequencer, timed in converter clocks
      unique case (s_q.seq)
         S_IDLE: begin
            if (TRIGGER) begin
               if (s_q.pre != 13'h0000) begin
                  s_d.seq = S_PRE1;
                  s_d.cnt = s_q.pre;
               end else begin
                  s_d.seq = S_ACQ1;
                  s_d.cnt = ACQ_CLKS;
               end
            end
         end
         S_PRE1, S_PRE2: begin
            if (s_q.ce) begin
               if (s_q.cnt <= 13'h0001) begin
                  s_d.seq = (s_q.seq == S_PRE1) ? S_ACQ1 : S_ACQ2;
                  s_d.cnt = ACQ_CLKS;
               end else begin
                  s_d.cnt = s_q.cnt - 13'h0001;
               end
            end
         end
         S_ACQ1, S_ACQ2: begin
            if (s_q.ce) begin
               if (s_q.cnt <= 13'h0001) begin
                  s_d.seq = (s_q.seq == S_ACQ1) ? S_CNV1 : S_CNV2;
                  s_d.cnt = CONV_CLKS;
               end else begin
                  s_d.cnt = s_q.cnt - 13'h0001;
               end
            end
         end
         S_CNV1: begin
            if (s_q.ce && s_q.cnt <= 13'h0001) begin
               if (!s_q.ctrl[CTL_DSE_BIT]) begin
                  s_d.seq = S_IDLE;
                  s_d.go  = 1'b1;
               end else if (s_q.ctrl[CTL_RPT_BIT]) begin
                  // Repeat mode retriggers itself, so no suspended gap
                  s_d.seq = (s_q.pre != 13'h0000) ? S_PRE2 : S_ACQ2;
                  s_d.cnt = (s_q.pre != 13'h0000) ? s_q.pre : ACQ_CLKS;
               end else begin
                  s_d.seq = S_SUSP;
               end
            end else if (s_q.ce) begin
               s_d.cnt = s_q.cnt - 13'h0001;
            end
         end
         S_SUSP: begin
            if (!s_q.ctrl[CTL_DSE_BIT]) begin
               s_d.seq = S_IDLE;
            end else if (TRIGGER) begin
               s_d.seq = (s_q.pre != 13'h0000) ? S_PRE2 : S_ACQ2;
               s_d.cnt = (s_q.pre != 13'h0000) ? s_q.pre : ACQ_CLKS;
            end
         end
         S_CNV2: begin
            if (s_q.ce && s_q.cnt <= 13'h0001) begin
               s_d.seq = S_IDLE;
               s_d.go  = 1'b1;
            end else if (s_q.ce) begin
               s_d.cnt = s_q.cnt - 13'h0001;
            end
         end
      endcase

      // Stage code is decoded from the next sequencer state, so it changes in the same cycle as the sequencer
      unique case (s_d.seq)
         S_IDLE:  s_d.stage = STG_IDLE;
         S_PRE1:  s_d.stage = STG_PRE1;
         S_ACQ1:  s_d.stage = STG_ACQ1;
         S_CNV1:  s_d.stage = STG_CNV1;
         S_SUSP:  s_d.stage = STG_SUSP;
         S_PRE2:  s_d.stage = STG_PRE2;
         S_ACQ2:  s_d.stage = STG_ACQ2;
         S_CNV2:  s_d.stage = STG_CNV2;
      endcase

      // Interrupt events: set wins over a same-cycle clear
      if (s_d.go) begin
         s_d.irq_sts[IRQ_DONE_BIT] = 1'b1;
      end
      if (DP_FLAGS.overflow) begin
         s_d.irq_sts[IRQ_OVF_BIT] = 1'b1;
      end
      if ((DP_FLAGS.above_upper && !s_q.uth) || (DP_FLAGS.below_lower && !s_q.lth)) begin
         s_d.irq_sts[IRQ_THR_BIT] = 1'b1;
      end
      s_d.irq = |(s_d.irq_sts & s_d.irq_msk);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_q         <= '0;
         s_q.seq     <= S_IDLE;
         s_q.chan    <= RST_INPUT_SEL;
         s_q.pre     <= RST_PRECHARGE;
         s_q.refsel  <= RST_REF_SEL;
         s_q.div     <= RST_CLK_DIV;
         s_q.ctrl    <= RST_CONTROL;
         s_q.irq_sts <= RST_IRQ;
         s_q.irq_msk <= RST_IRQ;
         s_q.stage   <= STG_IDLE;
         s_q.waitreq <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state register
   assign READDATA    = s_q.rdata;
   assign WAITREQUEST = s_q.waitreq;
   assign CONV_CLK_EN = s_q.ce;
   assign STAGE       = s_q.stage;
   assign COMPUTE_GO  = s_q.go;
   assign REF_SEL     = s_q.refsel;
   assign INPUT_SEL   = s_q.chan;
   assign IRQ         = s_q.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Gap between enables under a steady divider
   logic [7:0] gap_q;
   logic       gap_ok_q;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         gap_q    <= 8'h00;
         gap_ok_q <= 1'b0;
      end else begin
         gap_q    <= s_q.ce ? 8'h01 : gap_q + 8'h01;
         gap_ok_q <= (s_q.ce || gap_ok_q) && !s_q.ctrl[CTL_SRC_BIT] && !(wr_now && idx == IDX_CLK_DIV);
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence sq_first_done;
      s_q.seq == S_CNV1 && s_q.ce && s_q.cnt <= 13'h0001;
   endsequence
   sequence sq_paired;
      s_q.ctrl[CTL_DSE_BIT] && !s_q.ctrl[CTL_RPT_BIT];
   endsequence

   a_aov_sticky: assert property (DP_FLAGS.overflow |=> s_q.accum_overflow_flag) else $error("overflow flag not set");
   a_upper_follow: assert property (##1 s_q.uth == $past(DP_FLAGS.above_upper))
      else $error("upper flag wrong");
   a_lower_follow: assert property (##1 s_q.lth == $past(DP_FLAGS.below_lower))
      else $error("lower flag wrong");
   a_computation_updated_flag_set: assert property (DP_FLAGS.updated |=> s_q.computation_updated_flag) else $error("update flag not set");
   a_computation_updated_flag_hold: assert property (s_q.computation_updated_flag && suspended |=> s_q.computation_updated_flag)
      else $error("update flag cleared while suspended");
   a_stage_idle: assert property (s_q.seq == S_IDLE && !TRIGGER |=> STAGE == STG_IDLE)
      else $error("idle stage code wrong");
   // A trigger, or pair mode dropped, in the first suspended cycle ends the suspend one cycle later
   a_suspend_entry: assert property (sq_first_done ##0 sq_paired |=> STAGE == STG_SUSP
      ##1 (STAGE == STG_SUSP || $past(TRIGGER) || !$past(s_q.ctrl[CTL_DSE_BIT])))
      else $error("suspend code not shown");
   a_div_period: assert property (s_q.ce && gap_ok_q && gap_q > 8'h01 |-> gap_q == 8'({1'b0, div_lim} + 8'h01))
      else $error("divider period wrong");
   a_skip_pre: assert property (s_q.pre == 13'h0000 && s_q.seq == S_IDLE && TRIGGER |=> STAGE == STG_ACQ1)
      else $error("precharge not skipped");
   a_single_go: assert property (COMPUTE_GO && s_q.ctrl[CTL_DSE_BIT] |-> $past(s_q.seq) == S_CNV2)
      else $error("computation before second sample");

endmodule

/* test/ascc_regs_tb_top.sv */
// Purpose: Self-checking bench for the converter status, clock and channel register block
// Assumes: 250 MHz CLK, short acquisition and conversion counts set through parameters
// Notes:   Inputs move on the rising edge, outputs are looked at on the falling edge
`timescale 1ns/10ps
module ascc_regs_tb_top;
   import ascc_pkg::*;
   // ----------------------------------------
   // Signals, clock and counters
   // ----------------------------------------
   logic        clk, rst_n, rd, wr, rc_clk, trig, conv_en, go, irq, wait_req;
   logic [14:0] addr;
   logic [31:0] wdata, rdata, v;
   logic [3:0]  be;
   logic [2:0]  stage;
   logic [1:0]  ref_sel;
   logic [5:0]  in_sel;
   ascc_dp_t    dp;
   int          err_count, compares, go_cnt, susp_cnt, en_cnt, pre_cnt;

   // Short counts keep every conversion well under a hundred cycles
   ascc_regs #(.ACQ_CLKS(13'h0002), .CONV_CLKS(13'h0002)) ascc_regs_i (
      .CLK(clk), .RST_N(rst_n), .ADDRESS(addr), .READ(rd), .WRITE(wr), .WRITEDATA(wdata),
      .BYTEENABLE(be), .READDATA(rdata), .WAITREQUEST(wait_req), .RC_CLK(rc_clk), .TRIGGER(trig),
      .DP_FLAGS(dp), .CONV_CLK_EN(conv_en), .STAGE(stage), .COMPUTE_GO(go), .REF_SEL(ref_sel),
      .INPUT_SEL(in_sel), .IRQ(irq));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Event counters, cleared by the scenario that reads them
   always @(negedge clk) begin
      if (go === 1'b1) go_cnt++;
      if (stage === STG_SUSP) susp_cnt++;
      if (conv_en === 1'b1) en_cnt++;
      if (conv_en === 1'b1 && stage === STG_PRE1) pre_cnt++;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("Counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic hang(input string what);
      err_count++;
      $display("[ERR] %0t wait ran out: %s", $time, what);
      end_of_test();
   endtask

   // One Avalon access; request held until waitrequest is seen low, read data kept in v
   task automatic bus(input logic w, input logic [12:0] idx, input logic [31:0] d, input logic [3:0] b);
      int n;
      n = 0;
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      addr <= {idx, 2'b00};
      wdata <= d;
      be <= b;
      do begin
         @(negedge clk);
         n++;
      end while (wait_req !== 1'b0 && n < 50);
      if (n >= 50) hang("bus answer");
      v = rdata;
      @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic fire_trig();
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      @(negedge clk);
   endtask

   task automatic pulse_dp(input ascc_dp_t p);
      @(posedge clk);
      dp <= p;
      @(posedge clk);
      dp <= '0;
      repeat (3) @(negedge clk);
   endtask

   task automatic wait_stage(input logic [2:0] code);
      int n;
      n = 0;
      while (stage !== code) begin
         @(negedge clk);
         n++;
         if (n > 600) hang("stage code");
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [12:0] idx [5] = '{IDX_INPUT_SEL, IDX_PRECHARGE, IDX_STATUS, IDX_REF_SEL, IDX_CLK_DIV};
      foreach (idx[i]) begin
         bus(1'b0, idx[i], 32'h0, 4'h0);
         chk(v, 32'h0, "reset value");
      end
      // An unmapped place swallows writes and reads zero
      bus(1'b1, 13'h1d20, 32'h0000_00ff, 4'h1);
      bus(1'b0, 13'h1d20, 32'h0, 4'h0);
      chk(v, 32'h0, "unmapped read");
      $display("Test reset done");
   endtask

   task automatic t_select();
      logic [5:0] codes [9] = '{6'h3f, 6'h3e, 6'h3b, 6'h3a, 6'h10, 6'h17, 6'h0c, 6'h03, 6'h20};
      foreach (codes[i]) begin
         bus(1'b1, IDX_INPUT_SEL, {26'h0, codes[i]}, 4'h1);
         bus(1'b0, IDX_INPUT_SEL, 32'h0, 4'h0);
         chk(v, {26'h0, codes[i]}, "input readback");
         chk({26'h0, in_sel}, {26'h0, codes[i]}, "input port");
      end
      for (int r = 0; r < 4; r++) begin
         bus(1'b1, IDX_REF_SEL, r, 4'h1);
         bus(1'b0, IDX_REF_SEL, 32'h0, 4'h0);
         chk(v, r, "reference readback");
         chk({30'h0, ref_sel}, r, "reference port");
      end
      // Lanes of the 13-bit count are written apart
      bus(1'b1, IDX_PRECHARGE, 32'h0000_ffff, 4'h3);
      bus(1'b0, IDX_PRECHARGE, 32'h0, 4'h0);
      chk(v, 32'h0000_1fff, "precharge width");
      bus(1'b1, IDX_PRECHARGE, 32'h0000_0500, 4'h2);
      bus(1'b0, IDX_PRECHARGE, 32'h0, 4'h0);
      chk(v, 32'h0000_05ff, "precharge high byte");
      bus(1'b1, IDX_PRECHARGE, 32'h0000_0011, 4'h1);
      bus(1'b0, IDX_PRECHARGE, 32'h0, 4'h0);
      chk(v, 32'h0000_0511, "precharge low byte");
      $display("Test select done");
   endtask

   task automatic t_clock();
      int n [3] = '{0, 2, 63};
      int k;
      foreach (n[i]) begin
         bus(1'b1, IDX_CLK_DIV, n[i], 4'h1);
         repeat (140) @(negedge clk);
         k = 0;
         while (conv_en !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
         end
         k = 0;
         do begin
            @(negedge clk);
            k++;
         end while (conv_en !== 1'b1 && k < 300);
         if (k >= 300) hang("converter enable");
         chk(k, 2 * (n[i] + 1), "divider spacing");
      end
      // With the RC source the divider is bypassed: no RC edges, no enables
      bus(1'b1, IDX_CONTROL, 32'h0000_0004, 4'h1);
      repeat (8) @(negedge clk);
      en_cnt = 0;
      repeat (300) @(negedge clk);
      chk(en_cnt, 0, "RC source still");
      repeat (4) begin
         @(posedge clk);
         rc_clk <= 1'b1;
         repeat (6) @(posedge clk);
         rc_clk <= 1'b0;
         repeat (6) @(posedge clk);
      end
      repeat (10) @(negedge clk);
      chk(en_cnt, 4, "RC source edges");
      bus(1'b1, IDX_CONTROL, 32'h0, 4'h1);
      bus(1'b1, IDX_CLK_DIV, 32'h0, 4'h1);
      $display("Test clock done");
   endtask

   task automatic t_single();
      bus(1'b1, IDX_PRECHARGE, 32'h0, 4'h3);
      bus(1'b1, IDX_IRQ_MASK, 32'h0000_0001, 4'h1);
      go_cnt = 0;
      fire_trig();
      chk(stage, STG_ACQ1, "no precharge stage");
      wait_stage(STG_CNV1);
      wait_stage(STG_IDLE);
      // One more edge so the event counters have seen the last cycle
      @(negedge clk);
      chk(go_cnt, 1, "one computation");
      chk(irq, 1'b1, "done interrupt");
      bus(1'b1, IDX_IRQ_STS, 32'h0000_0001, 4'h1);
      @(negedge clk);
      chk(irq, 1'b0, "done cleared");
      bus(1'b1, IDX_PRECHARGE, 32'h0000_0003, 4'h3);
      pre_cnt = 0;
      fire_trig();
      chk(stage, STG_PRE1, "precharge stage");
      wait_stage(STG_IDLE);
      chk(pre_cnt, 3, "precharge clocks");
      $display("Test single done");
   endtask

   task automatic t_double();
      bus(1'b1, IDX_CONTROL, 32'h0000_0001, 4'h1);
      pulse_dp('{updated: 1'b1, default: 1'b0});
      go_cnt = 0;
      fire_trig();
      wait_stage(STG_SUSP);
      chk(go_cnt, 0, "no computation mid pair");
      repeat (20) @(negedge clk);
      chk(stage, STG_SUSP, "suspend holds");
      // Clearing the updated flag is refused while suspended
      bus(1'b1, IDX_STATUS, 32'h0, 4'h1);
      bus(1'b0, IDX_STATUS, 32'h0, 4'h0);
      chk(v & 32'h0000_001f, 32'h0000_0014, "suspend status");
      fire_trig();
      chk(stage, STG_PRE2, "second precharge");
      wait_stage(STG_ACQ2);
      wait_stage(STG_CNV2);
      wait_stage(STG_IDLE);
      @(negedge clk);
      chk(go_cnt, 1, "one computation per pair");
      bus(1'b1, IDX_STATUS, 32'h0, 4'h1);
      bus(1'b0, IDX_STATUS, 32'h0, 4'h0);
      chk(v & 32'h0000_0010, 32'h0, "updated flag cleared");
      // Repeat mode runs the pair without a suspend
      bus(1'b1, IDX_CONTROL, 32'h0000_0003, 4'h1);
      go_cnt = 0;
      susp_cnt = 0;
      fire_trig();
      wait_stage(STG_PRE2);
      wait_stage(STG_IDLE);
      @(negedge clk);
      chk(susp_cnt, 0, "no suspend in repeat");
      chk(go_cnt, 1, "one computation in repeat");
      bus(1'b1, IDX_CONTROL, 32'h0, 4'h1);
      $display("Test double done");
   endtask

   task automatic t_flags();
      @(posedge clk);
      dp.above_upper <= 1'b1;
      bus(1'b0, IDX_STATUS, 32'h0, 4'h0);
      chk(v & 32'h0000_00e0, 32'h0000_0040, "above upper");
      dp.above_upper <= 1'b0;
      dp.below_lower <= 1'b1;
      bus(1'b0, IDX_STATUS, 32'h0, 4'h0);
      chk(v & 32'h0000_00e0, 32'h0000_0020, "below lower");
      dp.below_lower <= 1'b0;
      bus(1'b1, IDX_IRQ_MASK, 32'h0000_0002, 4'h1);
      pulse_dp('{overflow: 1'b1, default: 1'b0});
      chk(irq, 1'b1, "overflow interrupt");
      bus(1'b0, IDX_STATUS, 32'h0, 4'h0);
      chk(v & 32'h0000_00e0, 32'h0000_0080, "overflow sticky");
      bus(1'b1, IDX_STATUS, 32'h0000_0080, 4'h1);
      bus(1'b0, IDX_STATUS, 32'h0, 4'h0);
      chk(v & 32'h0000_0080, 32'h0, "overflow cleared");
      bus(1'b1, IDX_IRQ_STS, 32'h0000_0002, 4'h1);
      @(negedge clk);
      chk(irq, 1'b0, "interrupt cleared");
      // Masked event still marks the status register but keeps the line low
      bus(1'b1, IDX_IRQ_MASK, 32'h0, 4'h1);
      pulse_dp('{overflow: 1'b1, default: 1'b0});
      bus(1'b0, IDX_IRQ_STS, 32'h0, 4'h0);
      chk(v & 32'h0000_0002, 32'h0000_0002, "masked event recorded");
      chk(irq, 1'b0, "masked interrupt");
      pulse_dp('{acc_clear: 1'b1, default: 1'b0});
      bus(1'b0, IDX_STATUS, 32'h0, 4'h0);
      chk(v & 32'h0000_0080, 32'h0, "accumulator clear");
      $display("Test flags done");
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      rc_clk = 1'b0;
      trig = 1'b0;
      addr = '0;
      wdata = '0;
      be = '0;
      dp = '0;
      err_count = 0;
      compares = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_select();
      t_clock();
      t_single();
      t_double();
      t_flags();
      end_of_test();
   end
endmodule
